// ---- dpw_consts.svh ----
// Constants of the DMA-driven PWM block: timing, field positions, loads.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DPW_CONSTS_SVH
`define DPW_CONSTS_SVH

// Clock rates in kHz and the division length in processor clocks
`define DPW_SYS_CLK_KHZ 100000
`define DPW_PROC_CLK_KHZ 9216
`define DPW_DIV_PROC_CYC 120
// Division in system cycles: 120 / 9.216 MHz, rounded down
`define DPW_DIV_CYCLES ((`DPW_DIV_PROC_CYC * `DPW_SYS_CLK_KHZ) / `DPW_PROC_CLK_KHZ)
`define DPW_DIV_LAST (11'(`DPW_DIV_CYCLES - 1))
// Period of 1024 divisions
`define DPW_DIV_IDX_W 10
`define DPW_DIV_IDX_LAST 10'h3FF
// Duty scale: 0 = off, 256 = always on
`define DPW_DUTY_W 9
`define DPW_DUTY_FULL 9'h100
// Simple interface accepts indices 0..3
`define DPW_IDX_MAX 3'h3
`define DPW_NUM_SIMPLE 4
// Output group write layout: bits 3..1 select, bit 0 state
`define DPW_SEL_MSB 3
`define DPW_SEL_LSB 1
`define DPW_STATE_BIT 0
`define DPW_RESERVED_SEL 3'h7
// Transfers loaded by init and refresh: two periods
`define DPW_DMA_LOAD 12'h800
// Fixed serial rate while PWM runs: 100 MHz / 4800
`define DPW_BAUD_BPS 4800
`define DPW_BAUD_DIV (16'(`DPW_SYS_CLK_KHZ * 1000 / `DPW_BAUD_BPS))

`endif

// ---- dpw_hv_load.sv ----
// Model of the high-voltage driver load hung on output bank B.
// Assumes hv_bank_b is settled at every rising edge of clk_sys.
module dpw_hv_load (
  input wire logic clk_sys,
  input wire logic [7:0] hv_bank_b,
  output int rise_at [8],
  output int edges [8]
);
  timeunit 1ns;
  timeprecision 100ps;
  int cyc;
  logic [7:0] prev_reg;

  ////////////////////////////////////////////////////////////////
  // Log first rise and every transition, per driver
  // Unknown levels before reset settles are not edges, so no false count
  initial begin
    cyc = 0;
    prev_reg = 8'h00;
    foreach (rise_at[i]) begin
      rise_at[i] = -1;
      edges[i] = 0;
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    for (int i = 0; i < 8; i++) begin
      if (!$isunknown(prev_reg[i]) && !$isunknown(hv_bank_b[i]) && hv_bank_b[i] != prev_reg[i]) begin
        edges[i]++;
        if (hv_bank_b[i] === 1'b1 && rise_at[i] < 0) begin
          rise_at[i] = cyc;
        end
      end
    end
    prev_reg = hv_bank_b;
  end
endmodule

// ---- dpw_latch.sv ----
// Bank of eight high-voltage output latches written one bit per byte.
// Assumes writes arrive as single-cycle strobes on the system clock.
`include "dpw_consts.svh"

module dpw_latch (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input dpw_pkg::dpw_latch_wr_t wr,
  output logic [7:0] hv_out
);

  logic [2:0] sel;

  // Upper four data bits are ignored
  assign sel = wr.data[`DPW_SEL_MSB:`DPW_SEL_LSB];

  ////////////////////////////////////////////////////////////////////////
  // One latch per output, loaded when selected
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      // R12: decode select and state
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          hv_out[g] <= 1'b0;
        end else if (clk_en && wr.strobe && sel == 3'(g)) begin
          hv_out[g] <= wr.data[`DPW_STATE_BIT];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  AST_LATCH_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    (clk_en && wr.strobe) |=> (hv_out[$past(sel)] == $past(wr.data[`DPW_STATE_BIT])))
    else $error("output latch did not take the written state");

endmodule

// ---- dpw_pkg.sv ----
// Types shared by the DMA-driven PWM block.
// Assumes nothing beyond a SystemVerilog compiler.
package dpw_pkg;

  // Host request, one-cycle strobes with their data
  typedef struct packed {
    logic init;
    logic refresh;
    logic duty_wr;
    logic [2:0] channel_index;
    logic [8:0] duty;
  } dpw_req_t;

  // Answer to a request
  typedef struct packed {
    logic valid;
    logic fail;
  } dpw_resp_t;

  // One byte written to an output group latch
  typedef struct packed {
    logic strobe;
    logic [7:0] data;
  } dpw_latch_wr_t;

  typedef enum logic [1:0] {
    DPW_ERR_NONE = 2'b00,
    DPW_ERR_INDEX = 2'b01,
    DPW_ERR_STOPPED = 2'b10
  } dpw_err_t;

  typedef enum logic [1:0] {
    DPW_ST_IDLE = 2'b00,
    DPW_ST_RUN = 2'b01,
    DPW_ST_STOPPED = 2'b10
  } dpw_state_t;

endpackage

// ---- dpw_top.sv ----
// DMA-driven PWM generator: division timer, transfer engine and latches.
// Assumes host strobes are synchronous to clk_sys and last one cycle.
//
// Functional notes
// R1: Drive outputs 0-6 only; output 7 reserved.
// R2: Period is exactly 1024 divisions.
// R3: Division lasts 120 processor clock cycles.
// R4: Each channel lags previous by one division.
// R5: Channel may change only every four divisions.
// R6: Duty is value/256; 0 off, 256 on.
// R7: Duty index 0-3 only; else error, fail.
// R8: Host initialises before writing any duty.
// R9: Host refreshes transfer count within 25 ms.
// R10: Count zero stops PWM; refresh reports failure.
// R11: Serial port fixed at 4800 bps while running.
// R12: Write bits 3-1 select, bit 0 state.
// R13: New duty applies from next channel period.
`include "dpw_consts.svh"

module dpw_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input dpw_pkg::dpw_req_t req,
  output dpw_pkg::dpw_resp_t resp,
  output dpw_pkg::dpw_err_t driver_error_code,
  output logic pwm_running,
  output logic [15:0] serial1_baud_div,
  output logic [7:0] hv_bank_b
);

  dpw_pkg::dpw_state_t state_reg;
  dpw_pkg::dpw_state_t state_next;
  logic [10:0] cyc_cnt_reg;
  logic [9:0] div_idx_reg;
  logic [11:0] dma_count_reg;
  logic [8:0] duty_reg [`DPW_NUM_SIMPLE];
  logic [8:0] active_duty_reg [`DPW_NUM_SIMPLE];
  dpw_pkg::dpw_latch_wr_t latch_wr_reg;
  logic div_tick;
  logic xfer_go;
  logic [1:0] slot;
  logic [9:0] phase;
  logic [7:0] step;
  logic [8:0] eff_duty;
  logic level;
  logic idx_ok;

  ////////////////////////////////////////////////////////////////////////
  // Division timer

  // R3: division end after DIV_CYCLES clocks
  assign div_tick = (cyc_cnt_reg == `DPW_DIV_LAST);

  // Timer runs only while the engine runs, so a fresh init starts clean
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cyc_cnt_reg <= 11'h000;
    end else if (clk_en) begin
      if (req.init || state_reg != dpw_pkg::DPW_ST_RUN || div_tick) begin
        cyc_cnt_reg <= 11'h000;
      end else begin
        cyc_cnt_reg <= cyc_cnt_reg + 11'h001;
      end
    end
  end

  // R2: period of 1024 divisions
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_idx_reg <= 10'h000;
    end else if (clk_en) begin
      if (req.init) begin
        div_idx_reg <= 10'h000;
      end else if (xfer_go) begin
        div_idx_reg <= div_idx_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine state

  assign xfer_go = div_tick && state_reg == dpw_pkg::DPW_ST_RUN;

  // R10: engine stops when the count runs out
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dpw_pkg::DPW_ST_IDLE: begin
        if (req.init) begin
          state_next = dpw_pkg::DPW_ST_RUN;
        end
      end
      dpw_pkg::DPW_ST_RUN: begin
        if (!req.init && xfer_go && dma_count_reg == 12'h001) begin
          state_next = dpw_pkg::DPW_ST_STOPPED;
        end
      end
      dpw_pkg::DPW_ST_STOPPED: begin
        if (req.init || req.refresh) begin
          state_next = dpw_pkg::DPW_ST_RUN;
        end
      end
      default: begin
        state_next = dpw_pkg::DPW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= dpw_pkg::DPW_ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Transfer count: loaded by init, or by refresh outside idle; one per division
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dma_count_reg <= 12'h000;
    end else if (clk_en) begin
      if (req.init || (req.refresh && state_reg != dpw_pkg::DPW_ST_IDLE)) begin
        dma_count_reg <= `DPW_DMA_LOAD;
      end else if (xfer_go) begin
        dma_count_reg <= dma_count_reg - 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform generation

  // R4: channel serviced this division; R5: every fourth division each
  assign slot = div_idx_reg[1:0];
  assign phase = div_idx_reg - {8'h00, slot};
  assign step = phase[9:2];
  // R13: staged duty takes over at channel period start
  assign eff_duty = (step == 8'h00) ? duty_reg[slot] : active_duty_reg[slot];
  // R6: on while step below duty; 0 never, 256 always
  assign level = ({1'b0, step} < eff_duty);

  // Duty staging per channel
  genvar c;
  generate
    for (c = 0; c < `DPW_NUM_SIMPLE; c++) begin : g_ch
      // R13: swap only at period start
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          active_duty_reg[c] <= 9'h000;
        end else if (clk_en) begin
          if (req.init) begin
            active_duty_reg[c] <= 9'h000;
          end else if (xfer_go && slot == 2'(c) && step == 8'h00) begin
            active_duty_reg[c] <= duty_reg[c];
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          duty_reg[c] <= 9'h000;
        end else if (clk_en) begin
          if (req.init) begin
            duty_reg[c] <= 9'h000;
          end else if (req.duty_wr && !req.refresh && req.channel_index == 3'(c)) begin
            duty_reg[c] <= req.duty;
          end
        end
      end

      AST_STAGED_DUTY: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
        (clk_en && !req.init && !(xfer_go && slot == 2'(c) && step == 8'h00))
          |=> $stable(active_duty_reg[c]))
        else $error("active duty changed away from period start");
    end
  endgenerate

  // R1: only channels 0-3 are ever selected; 7 stays reserved
  // R12: byte carries select in bits 3..1 and state in bit 0
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latch_wr_reg <= '0;
    end else if (clk_en) begin
      latch_wr_reg.strobe <= xfer_go && !req.init;
      latch_wr_reg.data <= {5'h00, slot, level};
    end
  end

  // Output latches for the second bank
  dpw_latch u_latch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr(latch_wr_reg),
    .hv_out(hv_bank_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Host answers and status

  assign idx_ok = (req.channel_index <= `DPW_IDX_MAX);

  // R7: bad index fails; R10: refresh fails on zero count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp <= '0;
    end else if (clk_en) begin
      resp.valid <= req.init || req.refresh || req.duty_wr;
      if (req.init) begin
        resp.fail <= 1'b0;
      end else if (req.refresh) begin
        resp.fail <= (dma_count_reg == 12'h000);
      end else begin
        resp.fail <= req.duty_wr && !idx_ok;
      end
    end
  end

  // Error code holds the last failure; init clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      driver_error_code <= dpw_pkg::DPW_ERR_NONE;
    end else if (clk_en) begin
      if (req.init) begin
        driver_error_code <= dpw_pkg::DPW_ERR_NONE;
      end else if (req.refresh && dma_count_reg == 12'h000) begin
        driver_error_code <= dpw_pkg::DPW_ERR_STOPPED;
      end else if (req.duty_wr && !req.refresh && !idx_ok) begin
        driver_error_code <= dpw_pkg::DPW_ERR_INDEX;
      end
    end
  end

  // R11: serial rate pinned while the engine runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_running <= 1'b0;
      serial1_baud_div <= 16'h0000;
    end else if (clk_en) begin
      pwm_running <= (state_next == dpw_pkg::DPW_ST_RUN);
      serial1_baud_div <= (state_next == dpw_pkg::DPW_ST_RUN) ? `DPW_BAUD_DIV : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_bad_index;
    clk_en && req.duty_wr && !req.init && !req.refresh && req.channel_index > `DPW_IDX_MAX;
  endsequence

  sequence s_fail_answer;
    resp.valid && resp.fail && driver_error_code == dpw_pkg::DPW_ERR_INDEX;
  endsequence

  AST_BAD_INDEX: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    s_bad_index |=> s_fail_answer)
    else $error("bad channel index not refused");

  AST_DIV_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    (clk_en && xfer_go && $past(clk_en)) |-> $past(cyc_cnt_reg) == (`DPW_DIV_LAST - 11'h001))
    else $error("division length wrong");

  AST_PERIOD_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    (clk_en && xfer_go && !req.init && div_idx_reg == `DPW_DIV_IDX_LAST) |=> div_idx_reg == 10'h000)
    else $error("period did not wrap at 1024 divisions");

  AST_NO_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    latch_wr_reg.strobe |-> latch_wr_reg.data[3:1] != `DPW_RESERVED_SEL && !latch_wr_reg.data[3])
    else $error("write reached a channel outside 0-3");

  AST_SLOT_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (clk_en && xfer_go && !req.init) |=> latch_wr_reg.data[2:1] == $past(div_idx_reg[1:0]))
    else $error("channel slot out of order");

  AST_DUTY_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    (clk_en && xfer_go && !req.init && eff_duty == 9'h000) |=> !latch_wr_reg.data[0])
    else $error("zero duty produced an on level");

  AST_DUTY_FULL: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    (clk_en && xfer_go && !req.init && eff_duty == `DPW_DUTY_FULL) |=> latch_wr_reg.data[0])
    else $error("full duty produced an off level");

  AST_STOP_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    (state_reg == dpw_pkg::DPW_ST_RUN) |-> dma_count_reg != 12'h000)
    else $error("engine running with zero count");

  AST_REFRESH_FAIL: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    (clk_en && req.refresh && !req.init && dma_count_reg == 12'h000) |=> resp.valid && resp.fail)
    else $error("refresh of a stopped engine not failed");

  AST_BAUD_FIXED: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    pwm_running |-> serial1_baud_div == `DPW_BAUD_DIV)
    else $error("serial divisor not fixed while running");

endmodule

// ---- dpw_top_bench.sv ----
// Self-checking bench for the DMA-driven PWM block, host side driven here.
// Assumes the design files and dpw_hv_load are compiled before this one.
`include "dpw_consts.svh"

module dpw_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys;
  logic rst_n;
  logic clk_en;
  dpw_pkg::dpw_req_t req;
  dpw_pkg::dpw_resp_t resp;
  dpw_pkg::dpw_err_t driver_error_code;
  logic pwm_running;
  logic [15:0] serial1_baud_div;
  logic [7:0] hv_bank_b;
  int rise_at [8];
  int edges [8];
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int init_at = 0;

  dpw_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req(req), .resp(resp),
    .driver_error_code(driver_error_code), .pwm_running(pwm_running),
    .serial1_baud_div(serial1_baud_div), .hv_bank_b(hv_bank_b));

  dpw_hv_load u_load (.clk_sys(clk_sys), .hv_bank_b(hv_bank_b), .rise_at(rise_at), .edges(edges));

  ////////////////////////////////////////////////////////////////
  // Clock and hang guard; whole run needs under 9000 cycles
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("MISMATCH run length expected under 20000 seen 20000");
      results();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Compare helpers, one per kind of result
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chki(string what, int exp, int got);
    n_tests++;
    if (got != exp) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // One strobe, then watch the answer pulse over three cycles
  task automatic request(logic ini, logic rfr, logic dw, logic [2:0] idx, logic [8:0] duty, logic exp_fail);
    int pulses;
    pulses = 0;
    req = '{ini, rfr, dw, idx, duty};
    @(posedge clk_sys);
    #1;
    req = '0;
    repeat (3) begin
      if (resp.valid === 1'b1) begin
        pulses++;
        chk("resp.fail", 16'(exp_fail), 16'(resp.fail));
      end
      @(posedge clk_sys);
      #1;
    end
    chki("resp.valid pulse count", 1, pulses);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("hv_bank_b", 16'h0000, 16'(hv_bank_b));
    chk("pwm_running", 16'h0000, 16'(pwm_running));
    chk("serial1_baud_div", 16'h0000, serial1_baud_div);
    chk("error code", 16'(dpw_pkg::DPW_ERR_NONE), 16'(driver_error_code));
    $display("test reset done");
  endtask

  task automatic t_refresh_idle();
    request(1'b0, 1'b1, 1'b0, 3'h0, 9'h000, 1'b1);
    chk("error code", 16'(dpw_pkg::DPW_ERR_STOPPED), 16'(driver_error_code));
    chk("pwm_running", 16'h0000, 16'(pwm_running));
    $display("test refresh before start done");
  endtask

  task automatic t_init();
    init_at = cyc;
    request(1'b1, 1'b0, 1'b0, 3'h0, 9'h000, 1'b0);
    chk("pwm_running", 16'h0001, 16'(pwm_running));
    chk("serial1_baud_div", `DPW_BAUD_DIV, serial1_baud_div);
    chk("error code", 16'(dpw_pkg::DPW_ERR_NONE), 16'(driver_error_code));
    $display("test start done");
  endtask

  // Bad indices first, then full duty on every legal channel
  task automatic t_index();
    for (int i = 4; i < 8; i++) begin
      request(1'b0, 1'b0, 1'b1, 3'(i), `DPW_DUTY_FULL, 1'b1);
      chk("error code", 16'(dpw_pkg::DPW_ERR_INDEX), 16'(driver_error_code));
    end
    for (int i = 0; i < 4; i++) begin
      request(1'b0, 1'b0, 1'b1, 3'(i), `DPW_DUTY_FULL, 1'b0);
    end
    $display("test channel index done");
  endtask

  task automatic t_refresh_run();
    // reload well inside the refresh interval
    request(1'b0, 1'b1, 1'b0, 3'h0, 9'h000, 1'b0);
    chk("pwm_running", 16'h0001, 16'(pwm_running));
    $display("test refresh while running done");
  endtask

  // Full duty: each channel rises once, one division after the one before
  task automatic t_waves();
    while (cyc < init_at + 5 * `DPW_DIV_CYCLES + 20) begin
      @(posedge clk_sys);
    end
    #1;
    for (int c = 1; c < 4; c++) begin
      chki("rise spacing", `DPW_DIV_CYCLES, rise_at[c] - rise_at[c - 1]);
    end
    for (int c = 0; c < 4; c++) begin
      chki("edges on full duty", 1, edges[c]);
    end
    for (int c = 4; c < 8; c++) begin
      chki("edges on unused output", 0, edges[c]);
    end
    chk("hv_bank_b", 16'h000F, 16'(hv_bank_b));
    $display("test waveforms done");
  endtask

  // Low enable ignores a restart, reset still acts, zero duty stays off
  task automatic t_freeze();
    clk_en = 1'b0;
    req = '{1'b1, 1'b0, 1'b0, 3'h0, 9'h000};
    @(posedge clk_sys);
    #1;
    req = '0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("resp.valid frozen", 16'h0000, 16'(resp.valid));
    chk("pwm_running frozen", 16'h0001, 16'(pwm_running));
    chk("hv_bank_b frozen", 16'h000F, 16'(hv_bank_b));
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("hv_bank_b in reset", 16'h0000, 16'(hv_bank_b));
    chk("pwm_running in reset", 16'h0000, 16'(pwm_running));
    rst_n = 1'b1;
    clk_en = 1'b1;
    request(1'b1, 1'b0, 1'b0, 3'h0, 9'h000, 1'b0);
    repeat (`DPW_DIV_CYCLES + 4) @(posedge clk_sys);
    #1;
    chk("hv_bank_b zero duty", 16'h0000, 16'(hv_bank_b));
    chk("pwm_running restarted", 16'h0001, 16'(pwm_running));
    $display("test freeze and restart done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the hang guard
  task automatic results();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset for five cycles, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    req = '0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_refresh_idle();
    t_init();
    t_index();
    t_refresh_run();
    t_waves();
    t_freeze();
    results();
  end
endmodule
